/* File: rtl/ifc_defines.svh */
// Constants for the IF filter calibration sequencer and its host
`ifndef IFC_DEFINES_SVH
`define IFC_DEFINES_SVH
// ==========================================
// Device latch indexes and fields
`define IFC_CTL_IDX 4'h0
`define IFC_BW_IDX 4'h4
`define IFC_CAL_IDX 4'h5
`define IFC_RB_IDX 4'h7
`define IFC_IDX_MSB 3
`define IFC_MUX_MSB 31
`define IFC_MUX_LSB 29
`define IFC_BW_MSB 31
`define IFC_BW_LSB 30
`define IFC_TRIM_MSB 19
`define IFC_TRIM_LSB 14
`define IFC_FINE_BIT 4
`define IFC_MANUAL_BIT 5
`define IFC_RB_EN_BIT 8
`define IFC_SEL_CAL_DONE 3'h5
`define IFC_SEL_CAL_BUSY 3'h6
// ==========================================
// Timing
`define IFC_CLK_MHZ 125
`define IFC_COARSE_US 200
`define IFC_FINE_US 5200
`define IFC_WORD_BITS 32
`define IFC_RB_BITS 16
`define IFC_RB_CLOCKS 18
`define IFC_SCLK_HALF 10
// ==========================================
// Host Avalon word indexes and bits
`define IFC_A_TX 4'h0
`define IFC_A_CMD 4'h1
`define IFC_A_STAT 4'h2
`define IFC_A_MASK 4'h3
`define IFC_A_RD 4'h4
`define IFC_A_STATE 4'h5
`define IFC_CMD_GO 0
`define IFC_CMD_RB 1
`define IFC_ST_DONE 0
`define IFC_ST_CAL 1
`define IFC_ST_REFUSED 2
`endif

/* File: rtl/ifc_dev.sv */
// Device end: serial latches, readback and IF filter calibration sequencer
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
`include "ifc_defines.svh"
// What this block does
// RULE1: Config register write starts self-running calibration
// RULE2: Host requests coarse calibration each receive power-up
// RULE3: Coarse calibration lasts two hundred microseconds
// RULE4: Fine request runs coarse step first
// RULE5: Status pin shows calibration complete when selected
// RULE6: Host stays off serial port during calibration
// RULE7: Host picks fine when bandwidth margin short
// RULE8: Fine result readable through serial readback
// RULE9: Manual trim field written, device applies it
// RULE10: Shift MSB first, latch by low nibble
// RULE11: Readback takes eighteen clocks, strobe held high
// RULE12: Trim holds last calibrated or written value
module ifc_dev
   import ifc_pkg::*;
#(
   parameter int COARSE_CYC = `IFC_COARSE_US * `IFC_CLK_MHZ,
   parameter int FINE_CYC = `IFC_FINE_US * `IFC_CLK_MHZ,
   parameter int TRIM_W = 6
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   ifc_link_if.dev LINK,
   input wire logic [TRIM_W-1:0] CAL_MEAS,
   output logic [TRIM_W-1:0] FILTER_TRIM,
   output logic [1:0] IF_BANDWIDTH_SELECT,
   output logic CAL_BUSY
);
   localparam int CNT_W = 20;
   // ==========================================
   // Pin synchronisers
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;
   logic [2:0] sync3_ff;
   wire logic [2:0] pins = {LINK.sclk, LINK.load_strobe, LINK.serial_write_in};
   wire logic strobe_s = sync2_ff[1];
   wire logic data_s = sync2_ff[0];
   wire logic sclk_rise = sync2_ff[2] & ~sync3_ff[2];
   wire logic strobe_rise = sync2_ff[1] & ~sync3_ff[1];
   wire logic strobe_fall = ~sync2_ff[1] & sync3_ff[1];

   // Two flops before any use; third flop only for edges
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         sync1_ff <= 3'h0;
         sync2_ff <= 3'h0;
         sync3_ff <= 3'h0;
      end else begin
         sync1_ff <= pins;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // ==========================================
   // Serial write shift register and latch decode
   logic [`IFC_WORD_BITS-1:0] shift_ff;
   wire logic shift_en = sclk_rise & ~strobe_s;
   wire logic [`IFC_IDX_MSB:0] idx = shift_ff[`IFC_IDX_MSB:0];
   wire logic wr_ctl = strobe_rise & (idx == `IFC_CTL_IDX);
   wire logic wr_bw = strobe_rise & (idx == `IFC_BW_IDX);
   wire logic wr_cal = strobe_rise & (idx == `IFC_CAL_IDX);
   wire logic wr_rb = strobe_rise & (idx == `IFC_RB_IDX);
   wire logic manual = shift_ff[`IFC_MANUAL_BIT];
   wire logic fine_req = shift_ff[`IFC_FINE_BIT];
   wire logic [TRIM_W-1:0] trim_field = shift_ff[`IFC_TRIM_MSB:`IFC_TRIM_LSB];

   // New bit enters at the LSB so the first bit ends at the MSB
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         shift_ff <= 32'h0000_0000;
      end else if (shift_en) begin
         shift_ff <= {shift_ff[`IFC_WORD_BITS-2:0], data_s}; // RULE10
      end
   end

   // ==========================================
   // Control latches
   logic [2:0] mux_sel_ff;
   logic [1:0] bw_ff;

   // Latch target chosen by the low nibble on strobe rise
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         mux_sel_ff <= 3'h0;
         bw_ff <= 2'h0;
      end else begin
         if (wr_ctl) begin
            mux_sel_ff <= shift_ff[`IFC_MUX_MSB:`IFC_MUX_LSB]; // RULE10
         end
         if (wr_bw) begin
            bw_ff <= shift_ff[`IFC_BW_MSB:`IFC_BW_LSB]; // RULE10
         end
      end
   end

   // ==========================================
   // Calibration sequencer
   ifc_cal_t state_ff;
   ifc_cal_t nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic fine_ff;
   logic done_ff;
   logic [TRIM_W-1:0] trim_ff;
   logic [TRIM_W-1:0] fine_res_ff;
   wire logic start = wr_cal & ~manual;
   wire logic coarse_end = (state_ff == CAL_COARSE) &
      (cnt_ff == CNT_W'(COARSE_CYC - 1));
   wire logic fine_end = (state_ff == CAL_FINE) &
      (cnt_ff == CNT_W'(FINE_CYC - 1));
   wire logic step_end = coarse_end | fine_end;

   // Next state; a fine request always goes through coarse first
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         CAL_IDLE: begin
            if (start) begin
               nxt_state = CAL_COARSE; // RULE1
            end
         end
         CAL_COARSE: begin
            if (coarse_end) begin
               nxt_state = fine_ff ? CAL_FINE : CAL_IDLE; // RULE4
            end
         end
         CAL_FINE: begin
            if (fine_end) begin
               nxt_state = CAL_IDLE;
            end
         end
         default: begin
            nxt_state = CAL_IDLE;
         end
      endcase
   end

   // Step counter restarts at each step boundary
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state_ff <= CAL_IDLE;
         cnt_ff <= 20'h0_0000;
      end else begin
         state_ff <= nxt_state;
         if (state_ff == CAL_IDLE || step_end) begin
            cnt_ff <= 20'h0_0000;
         end else begin
            cnt_ff <= cnt_ff + 20'h0_0001; // RULE3
         end
      end
   end

   // Fine flag captured at start; writes during a run are ignored
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         fine_ff <= 1'b0;
      end else if (start && state_ff == CAL_IDLE) begin
         fine_ff <= fine_req; // RULE4
      end
   end

   // Done flag: set at the end of the last step, cleared by a new start
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         done_ff <= 1'b0;
      end else if (step_end && nxt_state == CAL_IDLE) begin
         done_ff <= 1'b1; // RULE5
      end else if (start && state_ff == CAL_IDLE) begin
         done_ff <= 1'b0;
      end
   end

   // Trim only moves at a step end or a manual write
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         trim_ff <= 6'h00;
         fine_res_ff <= 6'h00;
      end else begin
         if (step_end) begin
            trim_ff <= CAL_MEAS; // RULE12
         end else if (wr_cal && manual && state_ff == CAL_IDLE) begin
            trim_ff <= trim_field; // RULE9
         end
         if (fine_end) begin
            fine_res_ff <= CAL_MEAS; // RULE8
         end
      end
   end

   // ==========================================
   // Readback: one dummy clock, 16 data bits, one release clock
   logic rb_arm_ff;
   logic [4:0] rb_cnt_ff;
   logic [`IFC_RB_BITS-1:0] rb_word_ff;
   logic rd_out_ff;
   logic rd_oe_ff;
   wire logic busy = (state_ff != CAL_IDLE);
   wire logic [`IFC_RB_BITS-1:0] rb_src = {done_ff, busy, bw_ff, 6'h00, fine_res_ff};
   wire logic rb_clk = sclk_rise & strobe_s & rb_arm_ff;
   wire logic rb_first = (rb_cnt_ff == 5'h00);
   wire logic rb_last = (rb_cnt_ff == 5'(`IFC_RB_CLOCKS - 1));

   // Arm on a readback latch; any strobe fall ends the read
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rb_arm_ff <= 1'b0;
         rb_cnt_ff <= 5'h00;
      end else if (wr_rb) begin
         rb_arm_ff <= shift_ff[`IFC_RB_EN_BIT]; // RULE11
         rb_cnt_ff <= 5'h00;
      end else if (strobe_fall) begin
         rb_arm_ff <= 1'b0;
      end else if (rb_clk) begin
         rb_cnt_ff <= rb_cnt_ff + 5'h01;
         if (rb_last) begin
            rb_arm_ff <= 1'b0; // RULE11
         end
      end
   end

   // Word captured on the dummy clock, shifted out MSB first
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rb_word_ff <= 16'h0000;
         rd_out_ff <= 1'b0;
         rd_oe_ff <= 1'b0;
      end else if (strobe_fall) begin
         rd_oe_ff <= 1'b0;
      end else if (rb_clk) begin
         if (rb_first) begin
            rb_word_ff <= rb_src; // RULE8
            rd_out_ff <= 1'b0;
            rd_oe_ff <= 1'b1;
         end else if (rb_last) begin
            rd_oe_ff <= 1'b0; // RULE11
         end else begin
            rd_out_ff <= rb_word_ff[`IFC_RB_BITS-1];
            rb_word_ff <= {rb_word_ff[`IFC_RB_BITS-2:0], 1'b0};
         end
      end
   end

   // ==========================================
   // Status pin and user-side outputs, all registered
   logic mux_ff;
   logic busy_ff;
   logic [1:0] bw_out_ff;
   wire logic nxt_mux = (mux_sel_ff == `IFC_SEL_CAL_DONE) ? done_ff :
      (mux_sel_ff == `IFC_SEL_CAL_BUSY) ? busy : 1'b0;

   // Unknown selections drive the pin low
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         mux_ff <= 1'b0;
         busy_ff <= 1'b0;
         bw_out_ff <= 2'h0;
      end else begin
         mux_ff <= nxt_mux; // RULE5
         busy_ff <= busy;
         bw_out_ff <= bw_ff;
      end
   end

   assign LINK.status_mux_pin = mux_ff;
   assign LINK.serial_read_out = rd_out_ff;
   assign LINK.serial_read_oe = rd_oe_ff;
   assign FILTER_TRIM = trim_ff;
   assign IF_BANDWIDTH_SELECT = bw_out_ff;
   assign CAL_BUSY = busy_ff;
endmodule : ifc_dev

/* File: rtl/ifc_host.sv */
// Host end: Avalon-MM registers driving the three-wire serial link
`timescale 1ns/10ps
`include "ifc_defines.svh"
module ifc_host
   import ifc_pkg::*;
#(
   parameter int HALF = `IFC_SCLK_HALF
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   ifc_link_if.host LINK,
   input wire logic [5:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic IRQ
);
   // ==========================================
   // Avalon slave: one wait cycle, then the access takes effect
   logic wait_ff;
   logic [31:0] rdata_ff;
   logic [31:0] tx_ff;
   logic [2:0] stat_ff;
   logic [2:0] mask_ff;
   logic [15:0] rd_ff;
   logic cal_wait_ff;
   ifc_host_t st_ff;
   wire logic req = AVS_READ | AVS_WRITE;
   wire logic [3:0] widx = AVS_ADDRESS[5:2];
   wire logic acc = AVS_WRITE & ~wait_ff;
   wire logic wr_cmd = acc & (widx == `IFC_A_CMD);
   wire logic busy = (st_ff != H_IDLE) | cal_wait_ff;
   wire logic go = wr_cmd & AVS_WRITEDATA[`IFC_CMD_GO] & ~busy;
   wire logic refused = wr_cmd & AVS_WRITEDATA[`IFC_CMD_GO] & busy; // RULE6
   wire logic [31:0] rmux =
      (widx == `IFC_A_TX) ? tx_ff :
      (widx == `IFC_A_STAT) ? {29'h0, stat_ff} :
      (widx == `IFC_A_MASK) ? {29'h0, mask_ff} :
      (widx == `IFC_A_RD) ? {16'h0, rd_ff} :
      (widx == `IFC_A_STATE) ? {27'h0, cal_wait_ff, 1'b0, st_ff} : 32'h0000_0000;

   // Unmapped reads return zero, unmapped writes are dropped
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else begin
         wait_ff <= ~(req & wait_ff);
         rdata_ff <= rmux;
      end
   end

   // ==========================================
   // Link pin synchronisers and status pin edge
   logic [1:0] s1_ff;
   logic [1:0] s2_ff;
   logic mux_d_ff;
   wire logic mux_rise = s2_ff[1] & ~mux_d_ff;

   // First stage feeds only the second
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         s1_ff <= 2'h0;
         s2_ff <= 2'h0;
         mux_d_ff <= 1'b0;
      end else begin
         s1_ff <= {LINK.status_mux_pin, LINK.serial_read_line};
         s2_ff <= s1_ff;
         mux_d_ff <= s2_ff[1];
      end
   end

   // ==========================================
   // Serial engine with sclk divider
   logic [7:0] div_ff;
   logic sclk_ff;
   logic sdat_ff;
   logic le_ff;
   logic rb_ff;
   logic [4:0] bit_ff;
   logic [31:0] sh_ff;
   wire logic tick = (div_ff == 8'(HALF - 1));
   wire logic fall = tick & sclk_ff;
   wire logic last_bit = (bit_ff == 5'(`IFC_WORD_BITS - 1));
   wire logic last_rb = (bit_ff == 5'(`IFC_RB_CLOCKS - 1));
   wire logic done_ev = tick & (st_ff == H_END);
   wire logic starts_cal = (tx_ff[`IFC_IDX_MSB:0] == `IFC_CAL_IDX) & ~tx_ff[`IFC_MANUAL_BIT];

   // Divider runs only while a frame is open
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         div_ff <= 8'h00;
      end else if (st_ff == H_IDLE || tick) begin
         div_ff <= 8'h00;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end

   // Data changes on falling sclk so it is steady at the rise
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         st_ff <= H_IDLE;
         sclk_ff <= 1'b0;
         sdat_ff <= 1'b0;
         le_ff <= 1'b0;
         rb_ff <= 1'b0;
         bit_ff <= 5'h00;
         sh_ff <= 32'h0000_0000;
         rd_ff <= 16'h0000;
      end else begin
         unique case (st_ff)
            H_IDLE: begin
               if (go) begin
                  st_ff <= H_SHIFT;
                  sdat_ff <= tx_ff[31]; // RULE10
                  sh_ff <= {tx_ff[30:0], 1'b0};
                  rb_ff <= AVS_WRITEDATA[`IFC_CMD_RB];
                  bit_ff <= 5'h00;
               end
            end
            H_SHIFT: begin
               if (tick) begin
                  sclk_ff <= ~sclk_ff;
               end
               if (fall) begin
                  sdat_ff <= sh_ff[31];
                  sh_ff <= {sh_ff[30:0], 1'b0};
                  bit_ff <= bit_ff + 5'h01;
                  if (last_bit) begin
                     st_ff <= H_LATCH;
                  end
               end
            end
            H_LATCH: begin
               if (tick) begin
                  le_ff <= 1'b1; // RULE10
                  bit_ff <= 5'h00;
                  st_ff <= rb_ff ? H_READ : H_END;
               end
            end
            H_READ: begin
               if (tick) begin
                  sclk_ff <= ~sclk_ff;
               end
               if (fall) begin
                  bit_ff <= bit_ff + 5'h01;
                  if (bit_ff != 5'h00 && !last_rb) begin
                     rd_ff <= {rd_ff[14:0], s2_ff[0]}; // RULE11
                  end
                  if (last_rb) begin
                     st_ff <= H_END;
                  end
               end
            end
            H_END: begin
               if (tick) begin
                  le_ff <= 1'b0; // RULE11
                  st_ff <= H_IDLE;
               end
            end
            default: begin
               st_ff <= H_IDLE;
            end
         endcase
      end
   end

   // Calibration wait: set after a start word, cleared by done on the pin
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         cal_wait_ff <= 1'b0;
      end else if (done_ev && starts_cal) begin
         cal_wait_ff <= 1'b1; // RULE6
      end else if (mux_rise) begin
         cal_wait_ff <= 1'b0;
      end
   end

   // ==========================================
   // Registers, sticky status (set beats clear), interrupt
   wire logic [2:0] ev = {refused, mux_rise, done_ev};
   wire logic [2:0] w1c = (acc && widx == `IFC_A_STAT) ? AVS_WRITEDATA[2:0] : 3'h0;
   logic irq_ff;

   // Software writes and status bookkeeping
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         tx_ff <= 32'h0000_0000;
         mask_ff <= 3'h0;
         stat_ff <= 3'h0;
         irq_ff <= 1'b0;
      end else begin
         if (acc && widx == `IFC_A_TX && !busy) begin
            tx_ff <= AVS_WRITEDATA;
         end
         if (acc && widx == `IFC_A_MASK) begin
            mask_ff <= AVS_WRITEDATA[2:0];
         end
         stat_ff <= (stat_ff & ~w1c) | ev;
         irq_ff <= |(stat_ff & mask_ff);
      end
   end

   assign AVS_WAITREQUEST = wait_ff;
   assign AVS_READDATA = rdata_ff;
   assign IRQ = irq_ff;
   assign LINK.sclk = sclk_ff;
   assign LINK.serial_write_in = sdat_ff;
   assign LINK.load_strobe = le_ff;
endmodule : ifc_host

/* File: rtl/ifc_link_if.sv */
// Three-wire serial link plus status pin between host and device
`timescale 1ns/10ps
interface ifc_link_if;
   logic sclk;
   logic serial_write_in;
   logic load_strobe;
   logic serial_read_out;
   logic serial_read_oe;
   logic serial_read_line;
   logic status_mux_pin;
   // ==========================================
   // Read pin level: undriven line reads low
   assign serial_read_line = serial_read_oe & serial_read_out;
   modport dev (
      input sclk, serial_write_in, load_strobe,
      output serial_read_out, serial_read_oe, status_mux_pin
   );
   modport host (
      output sclk, serial_write_in, load_strobe,
      input serial_read_line, status_mux_pin
   );
endinterface : ifc_link_if

/* File: rtl/ifc_pkg.sv */
// Types shared by both ends of the calibration link
package ifc_pkg;
   // ==========================================
   // Device calibration sequencer states
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_COARSE = 2'b01,
      CAL_FINE = 2'b10
   } ifc_cal_t;
   // ==========================================
   // Host serial engine states
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_SHIFT = 3'b001,
      H_LATCH = 3'b010,
      H_READ = 3'b011,
      H_END = 3'b100
   } ifc_host_t;
endpackage : ifc_pkg

/* File: test/ifc_link_monitor.sv */
// Checker for the serial link between host and device ends
`timescale 1ns/10ps
module ifc_link_monitor (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic sclk,
   input wire logic serial_write_in,
   input wire logic load_strobe,
   input wire logic serial_read_out,
   input wire logic serial_read_oe,
   input wire logic serial_read_line,
   input wire logic status_mux_pin
);
   logic sclk_ff;
   logic [4:0] rb_cnt_ff;
   logic [4:0] nxt_rb_cnt;
   // ==========================================
   // Serial clock rises counted while strobe high
   assign nxt_rb_cnt = !load_strobe ? 5'h00 : rb_cnt_ff + {4'h0, sclk & !sclk_ff};
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         sclk_ff <= 1'b0;
         rb_cnt_ff <= 5'h00;
      end else begin
         sclk_ff <= sclk;
         rb_cnt_ff <= nxt_rb_cnt;
      end
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   // ==========================================
   // Write framing
   data_at_low_a: assert property ($changed(serial_write_in) |-> !sclk)
      else $error("write data moved while serial clock high");
   sclk_high_a: assert property ($rose(sclk) |-> sclk [*8])
      else $error("serial clock high phase too short");
   strobe_idle_a: assert property ($rose(load_strobe) |-> !sclk && !$past(sclk))
      else $error("strobe rose near a clock edge");
   // ==========================================
   // Readback framing
   rb_window_a: assert property (serial_read_oe |-> rb_cnt_ff >= 5'h01 && rb_cnt_ff <= 5'h12)
      else $error("read pin driven outside the clock window");
   rb_count_a: assert property ($fell(load_strobe) |-> rb_cnt_ff == 5'h00 || rb_cnt_ff == 5'h12)
      else $error("readback not eighteen clocks");
   rb_release_a: assert property ($fell(load_strobe) |-> ##[0:4] !serial_read_oe)
      else $error("read pin not released");
   dummy_low_a: assert property ($rose(serial_read_oe) |-> !serial_read_out)
      else $error("first readback bit not the dummy");
   rd_hold_a: assert property (serial_read_oe && $fell(sclk) |-> $stable(serial_read_line))
      else $error("read bit moved at host sampling edge");
   // Calibration ends only while the port is quiet
   cal_quiet_a: assert property ($rose(status_mux_pin) |-> !sclk && !load_strobe)
      else $error("serial traffic during calibration");
endmodule : ifc_link_monitor

/* File: test/tb.sv */
// Testbench joining host and device ends of the calibration link
`timescale 1ns/10ps
module tb;
   localparam int COARSE = 20;
   localparam int FINE = 40;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   logic [5:0] cal_meas = 6'h00;
   logic [5:0] filter_trim;
   logic [1:0] bw_sel;
   logic cal_busy;
   logic [15:0] rnd = 16'hAD13;
   logic [1:0] m_bw;
   logic m_mask;
   logic [5:0] meas_q[$];
   logic [31:0] q;
   int n_errors = 0;
   int total_checks = 0;
   int busy_run = 0;
   int last_len = 0;
   int n_runs = 0;
   int r0;
   int i;
   int n;
   always #4 clock = ~clock;
   ifc_link_if ifc_link_if_inst ();
   ifc_dev #(.COARSE_CYC(COARSE), .FINE_CYC(FINE)) ifc_dev_inst (.CLOCK(clock), .RST_N(rst_n),
      .LINK(ifc_link_if_inst), .CAL_MEAS(cal_meas), .FILTER_TRIM(filter_trim),
      .IF_BANDWIDTH_SELECT(bw_sel), .CAL_BUSY(cal_busy));
   ifc_host ifc_host_inst (.CLOCK(clock), .RST_N(rst_n), .LINK(ifc_link_if_inst),
      .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
      .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq));
   ifc_link_monitor ifc_link_monitor_inst (.CLOCK(clock), .RST_N(rst_n),
      .sclk(ifc_link_if_inst.sclk), .serial_write_in(ifc_link_if_inst.serial_write_in),
      .load_strobe(ifc_link_if_inst.load_strobe),
      .serial_read_out(ifc_link_if_inst.serial_read_out),
      .serial_read_oe(ifc_link_if_inst.serial_read_oe),
      .serial_read_line(ifc_link_if_inst.serial_read_line),
      .status_mux_pin(ifc_link_if_inst.status_mux_pin));
   // ==========================================
   // Length of the last busy stretch
   always @(posedge clock) begin
      busy_run <= (cal_busy === 1'b1) ? busy_run + 1 : 0;
      if (cal_busy !== 1'b1 && busy_run != 0) last_len <= busy_run;
      if (cal_busy !== 1'b1 && busy_run != 0) n_runs <= n_runs + 1;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk_val
   // Busy length allows two cycles of sync slack either way
   task automatic chk_time(input string what, input int exp, input int got);
      total_checks++;
      if (got < exp - 2 || got > exp + 2) begin
         n_errors++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask : chk_time
   // ==========================================
   // Avalon access, held until waitrequest sampled low; only the watchdog ends a hang
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] rq);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clock);
      end
      rq = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask : bus
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] dq;
      bus(1'b1, a, d, dq);
   endtask : wr
   task automatic go(input logic [31:0] w, input logic [31:0] cmd);
      wr(6'h00, w);
      wr(6'h04, cmd);
   endtask : go
   // Waits for transfer done, checks the interrupt, clears status
   task automatic fin;
      logic [31:0] sq;
      int k;
      sq = 32'h0000_0000;
      for (k = 0; k < 2000 && sq[0] !== 1'b1; k++) bus(1'b0, 6'h08, 32'h0, sq);
      chk_val("transfer done", 32'h0000_0001, {31'h0, sq[0]});
      chk_val("irq", {31'h0, m_mask}, {31'h0, irq});
      wr(6'h08, 32'h0000_0007);
      @(posedge clock);
      chk_val("irq clear", 32'h0000_0000, {31'h0, irq});
   endtask : fin
   task automatic new_meas;
      rnd = lfsr(rnd);
      cal_meas <= rnd[5:0];
      meas_q.push_back(rnd[5:0]);
   endtask : new_meas
   task automatic finish_test;
      $display("checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test
   // Watchdog well beyond the expected span
   initial begin
      #(8 * 40000);
      n_errors++;
      finish_test;
   end
   // ==========================================
   // Main sequence
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      for (i = 2; i < 6; i += 3) begin
         bus(1'b0, i[5:0] << 2, 32'h0, q);
         chk_val("reset value", 32'h0000_0000, q);
      end
      bus(1'b0, 6'h18, 32'h0, q);
      chk_val("unmapped", 32'h0000_0000, q);
      m_mask = 1'b1;
      wr(6'h0C, 32'h0000_0001);
      bus(1'b0, 6'h0C, 32'h0, q);
      chk_val("mask", 32'h0000_0001, q);
      go(32'hA000_0000, 32'h0000_0001);
      fin;
      for (i = 0; i < 4; i++) begin
         m_mask = i[0];
         m_bw = i[1:0];
         wr(6'h0C, {31'h0, m_mask});
         go({m_bw, 26'h0, 4'h4}, 32'h0000_0001);
         fin;
         chk_val("bandwidth", {30'h0, m_bw}, {30'h0, bw_sel});
      end
      go(32'h0000_0003, 32'h0000_0001);
      fin;
      chk_val("foreign index", {30'h0, m_bw}, {30'h0, bw_sel});
      $display("test latches done");
      new_meas;
      r0 = n_runs;
      go(32'h0000_0005, 32'h0000_0001);
      fin;
      for (n = 0; n < 500 && n_runs == r0; n++) @(posedge clock);
      chk_time("coarse length", COARSE, last_len);
      chk_val("coarse trim", {26'h0, meas_q[$]}, {26'h0, filter_trim});
      $display("test coarse done");
      new_meas;
      r0 = n_runs;
      go(32'h0000_0015, 32'h0000_0001);
      for (n = 0; n < 2000 && cal_busy !== 1'b1; n++) @(posedge clock);
      wr(6'h04, 32'h0000_0001);
      bus(1'b0, 6'h08, 32'h0, q);
      chk_val("refused", 32'h0000_0001, {31'h0, q[2]});
      bus(1'b0, 6'h14, 32'h0, q);
      chk_val("cal wait", 32'h0000_0001, {31'h0, q[4]});
      for (n = 0; n < 200 && busy_run < COARSE + 3; n++) @(posedge clock);
      chk_val("coarse step trim", {26'h0, meas_q[$]}, {26'h0, filter_trim});
      new_meas;
      fin;
      for (n = 0; n < 500 && n_runs == r0; n++) @(posedge clock);
      chk_time("fine length", COARSE + FINE, last_len);
      chk_val("fine trim", {26'h0, meas_q[$]}, {26'h0, filter_trim});
      // Pin rise needs the host synchroniser delay before it shows in status
      repeat (4) @(posedge clock);
      bus(1'b0, 6'h08, 32'h0, q);
      chk_val("status pin rose", 32'h0000_0001, {31'h0, q[1]});
      go(32'h0000_0107, 32'h0000_0003);
      fin;
      bus(1'b0, 6'h10, 32'h0, q);
      chk_val("readback", {16'h0, 2'b10, m_bw, 6'h00, meas_q[$]}, q);
      $display("test fine done");
      rnd = lfsr(rnd);
      r0 = n_runs;
      go({12'h000, rnd[5:0], 8'h00, 6'h25}, 32'h0000_0001);
      fin;
      chk_val("manual trim", {26'h0, rnd[5:0]}, {26'h0, filter_trim});
      cal_meas <= ~rnd[5:0];
      repeat (50) @(posedge clock);
      chk_val("no calibration", r0, n_runs);
      chk_val("trim held", {26'h0, rnd[5:0]}, {26'h0, filter_trim});
      $display("test manual done");
      finish_test;
   end
endmodule : tb
